/* rtl/rfid_channel_cmd_buffer.sv */
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
module rfid_channel_cmd_buffer #(
  parameter int DEPTH = 8,
  parameter int EPC_BYTES = 4,
  parameter int CFG_WORDS = 16
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Controller link.
  rfid_cmd_link_if.dev lk,
  // Reader tag stream.
  input wire logic i_tag_valid,
  input wire logic [8*EPC_BYTES-1:0] i_tag_epc,
  // Reader transaction port.
  output logic o_rdr_req,
  output rfid_chan_pkg::rdr_op_t o_rdr_op,
  output logic [$clog2(CFG_WORDS)-1:0] o_rdr_addr,
  output logic [7:0] o_rdr_wdata,
  input wire logic i_rdr_ack,
  input wire logic i_rdr_fault,
  input wire logic [7:0] i_rdr_rdata
);
  import rfid_chan_pkg::*;
  localparam int REC_BYTES = EPC_BYTES + 1;
  localparam int REC_W = 8 * REC_BYTES;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(CFG_WORDS);

  typedef enum logic [1:0] {S_IDLE = 2'b00, S_RDR = 2'b01, S_BUF = 2'b10} st_t;
  typedef struct packed {
    st_t st;
    logic [7:0] op_sel;
    logic [7:0] diag_sup;
    logic [7:0] retry;
    logic [15:0] rd_len;
    logic [15:0] wr_len;
    logic [DEPTH-1:0][REC_W-1:0] mem;
    logic [PW-1:0] head;
    logic [PW-1:0] tail;
    logic [PW:0] nrec;
    logic [7:0] head_off;
    logic sensing;
    logic group_on;
    logic [15:0] cur_cmd;
    logic err;
    logic busy;
    logic [7:0] tries;
    logic [15:0] remain;
    logic [7:0] rd_idx;
    logic [1:0] diag_flags;
    logic [CFG_WORDS-1:0][7:0] cfg;
    logic [CW-1:0] cfg_idx;
    rdr_op_t rop;
    logic rdr_req;
    logic [7:0] rdr_wdata;
    logic [7:0] par_rdata;
    logic [15:0] resp;
    logic [15:0] byte_cnt;
    logic [15:0] diag;
    logic [15:0] rd_area;
    logic [15:0] wr_area;
    logic rd_valid;
    logic [7:0] rd_data;
    logic [7:0] rd_pd_byte;
  } state_t;

  state_t r_reg;
  state_t r_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Smaller of two 16-bit lengths.
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction : min16

  // Bytes still held in the buffer.
  function automatic logic [15:0] fifo_bytes(input logic [PW:0] nrec, input logic [7:0] off);
    return 16'(nrec * REC_BYTES) - {8'h00, off};
  endfunction : fifo_bytes

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // All state moves here; a read pops first, so a freed slot serves a new tag.
  always_comb begin
    logic hit;
    logic [PW-1:0] k, hk;
    hit = 1'b0;
    k = '0;
    hk = '0;
    r_next = r_reg;
    r_next.rd_valid = 1'b0;
    // Parameter bytes from the controller; reserved bytes are ignored.
    if (lk.par_wr) begin
      unique case (lk.par_idx)
        PAR_OP_SEL: r_next.op_sel = lk.par_wdata;
        PAR_DIAG_SUP: r_next.diag_sup = lk.par_wdata;
        PAR_RETRY: r_next.retry = lk.par_wdata;
        PAR_RD_LEN: r_next.rd_len[7:0] = lk.par_wdata;
        PAR_RD_LEN_HI: r_next.rd_len[15:8] = lk.par_wdata;
        PAR_WR_LEN: r_next.wr_len[7:0] = lk.par_wdata;
        PAR_WR_LEN_HI: r_next.wr_len[15:8] = lk.par_wdata;
        default: ;
      endcase
    end
    if (lk.par_rd) begin
      unique case (lk.par_idx)
        PAR_OP_SEL: r_next.par_rdata = r_reg.op_sel;
        PAR_DIAG_SUP: r_next.par_rdata = r_reg.diag_sup;
        PAR_RETRY: r_next.par_rdata = r_reg.retry;
        PAR_RD_LEN: r_next.par_rdata = r_reg.rd_len[7:0];
        PAR_RD_LEN_HI: r_next.par_rdata = r_reg.rd_len[15:8];
        PAR_WR_LEN: r_next.par_rdata = r_reg.wr_len[7:0];
        PAR_WR_LEN_HI: r_next.par_rdata = r_reg.wr_len[15:8];
        default: r_next.par_rdata = 8'h00;
      endcase
    end
    // Command sequencer.
    unique case (r_reg.st)
      S_IDLE: begin
        if (lk.cmd_valid) begin
          r_next.cur_cmd = lk.cmd_word;
          r_next.err = 1'b0;
          r_next.tries = 8'h00;
          r_next.cfg_idx = '0;
          if (r_reg.op_sel == MODE_OFF && lk.cmd_word != CMD_IDLE) begin
            r_next.err = 1'b1;
          end else begin
            unique case (lk.cmd_word)
              CMD_IDLE: ;
              CMD_SENSE: begin
                r_next.group_on = (lk.cmd_addr == 8'h01);
                r_next.rop = OP_SENSE;
                r_next.rdr_req = 1'b1;
                r_next.st = S_RDR;
              end
              CMD_BUF_READ: begin
                if (r_reg.op_sel != MODE_ADVANCED) begin
                  r_next.err = 1'b1;
                end else begin
                  r_next.remain = min16(min16(lk.cmd_len, r_reg.byte_cnt), r_reg.rd_area);
                  r_next.rd_idx = 8'h00;
                  r_next.st = (r_next.remain != 16'h0000) ? S_BUF : S_IDLE;
                end
              end
              CMD_RESET: begin
                r_next.sensing = 1'b0;
                r_next.head = '0;
                r_next.tail = '0;
                r_next.nrec = '0;
                r_next.head_off = 8'h00;
                r_next.diag_flags = 2'b00;
              end
              CMD_BACKUP: begin
                r_next.rop = OP_CFG_RD;
                r_next.rdr_req = 1'b1;
                r_next.st = S_RDR;
              end
              CMD_RESTORE: begin
                r_next.rop = OP_CFG_WR;
                r_next.rdr_wdata = r_reg.cfg[0];
                r_next.rdr_req = 1'b1;
                r_next.st = S_RDR;
              end
              default: r_next.err = 1'b1;
            endcase
          end
        end
      end
      S_RDR: begin
        if (i_rdr_ack) begin
          if (i_rdr_fault) begin
            if (r_reg.tries < r_reg.retry) begin
              r_next.tries = r_reg.tries + 8'h01;
            end else begin
              r_next.err = 1'b1;
              r_next.diag_flags[DIAG_FAULT_BIT] = 1'b1;
              r_next.rdr_req = 1'b0;
              r_next.st = S_IDLE;
            end
          end else begin
            r_next.tries = 8'h00;
            if (r_reg.rop == OP_CFG_RD) begin
              r_next.cfg[r_reg.cfg_idx] = i_rdr_rdata;
            end
            if (r_reg.rop == OP_SENSE || r_reg.cfg_idx == CW'(CFG_WORDS - 1)) begin
              r_next.sensing = r_reg.sensing | (r_reg.rop == OP_SENSE);
              r_next.rdr_req = 1'b0;
              r_next.st = S_IDLE;
            end else begin
              r_next.cfg_idx = r_reg.cfg_idx + CW'(1);
              r_next.rdr_wdata = r_reg.cfg[r_next.cfg_idx];
            end
          end
        end
      end
      S_BUF: begin
        // One byte per cycle from the head record into the read area.
        r_next.rd_valid = 1'b1;
        r_next.rd_data = r_reg.mem[r_reg.head][8*r_reg.head_off +: 8];
        r_next.rd_pd_byte = PD_DATA_FIRST + r_reg.rd_idx;
        r_next.rd_idx = r_reg.rd_idx + 8'h01;
        r_next.remain = r_reg.remain - 16'h0001;
        if (r_reg.head_off == 8'(REC_BYTES - 1)) begin
          r_next.head_off = 8'h00;
          r_next.head = r_reg.head + PW'(1);
          r_next.nrec = r_reg.nrec - (PW+1)'(1);
        end else begin
          r_next.head_off = r_reg.head_off + 8'h01;
        end
        if (r_reg.remain == 16'h0001) begin
          r_next.st = S_IDLE;
        end
      end
      default: r_next.st = S_IDLE;
    endcase
    // Tag capture while sensing, also across idle commands.
    if (r_reg.sensing && r_next.sensing && i_tag_valid) begin
      for (int i = 0; i < DEPTH; i++) begin
        k = r_next.head + PW'(i);
        if ((PW+1)'(i) < r_next.nrec && !(i == 0 && r_next.head_off != 8'h00) && !hit &&
            r_next.mem[k][REC_W-1:8] == i_tag_epc) begin
          hit = 1'b1;
          hk = k;
        end
      end
      if (r_next.group_on && hit) begin
        if (r_next.mem[hk][7:0] != 8'hff) begin
          r_next.mem[hk][7:0] = r_next.mem[hk][7:0] + 8'h01;
        end
      end else if (r_next.nrec == (PW+1)'(DEPTH)) begin
        r_next.diag_flags[DIAG_OVFL_BIT] = 1'b1;
      end else begin
        r_next.mem[r_next.tail] = {i_tag_epc, 8'h01};
        r_next.tail = r_next.tail + PW'(1);
        r_next.nrec = r_next.nrec + (PW+1)'(1);
      end
    end
    // Visible status follows the state it describes.
    r_next.busy = (r_next.st != S_IDLE);
    r_next.resp = {r_next.busy, r_next.err, 2'b00, r_next.cur_cmd[11:0]};
    r_next.byte_cnt = fifo_bytes(r_next.nrec, r_next.head_off);
    r_next.diag = (r_next.diag_sup == 8'h01 || r_next.op_sel == MODE_OFF) ? 16'h0000 :
                  {14'h0000, r_next.diag_flags};
    r_next.rd_area = min16(r_next.rd_len, DATA_AREA_MAX);
    r_next.wr_area = min16(r_next.wr_len, DATA_AREA_MAX);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  // Synchronous reset; the tag memory is cleared too so no stale EPC can match.
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      r_reg <= '0;
      r_reg.op_sel <= OP_SEL_RST;
      r_reg.diag_sup <= DIAG_SUP_RST;
      r_reg.retry <= RETRY_RST;
      r_reg.rd_len <= RD_LEN_RST;
      r_reg.wr_len <= WR_LEN_RST;
      r_reg.rd_area <= RD_LEN_RST;
      r_reg.wr_area <= WR_LEN_RST;
      r_reg.rop <= OP_SENSE;
      r_reg.st <= S_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.

  assign lk.par_rdata = r_reg.par_rdata;
  assign lk.response_word = r_reg.resp;
  assign lk.buffered_byte_count = r_reg.byte_cnt;
  assign lk.diag_word = r_reg.diag;
  assign lk.rd_area = r_reg.rd_area;
  assign lk.wr_area = r_reg.wr_area;
  assign lk.rd_valid = r_reg.rd_valid;
  assign lk.rd_data = r_reg.rd_data;
  assign lk.rd_pd_byte = r_reg.rd_pd_byte;
  assign o_rdr_req = r_reg.rdr_req;
  assign o_rdr_op = r_reg.rop;
  assign o_rdr_addr = r_reg.cfg_idx;
  assign o_rdr_wdata = r_reg.rdr_wdata;
endmodule : rfid_channel_cmd_buffer

/* rtl/rfid_chan_pkg.sv */
package rfid_chan_pkg;
  // Clock and timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int STABLE_TIME_NS = 1000;
  localparam int STABLE_CYCLES = (STABLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Channel parameter byte offsets.
  localparam logic [5:0] PAR_OP_SEL = 6'h00;
  localparam logic [5:0] PAR_DIAG_SUP = 6'h05;
  localparam logic [5:0] PAR_RETRY = 6'h08;
  localparam logic [5:0] PAR_RD_LEN = 6'h20;
  localparam logic [5:0] PAR_RD_LEN_HI = 6'h21;
  localparam logic [5:0] PAR_WR_LEN = 6'h22;
  localparam logic [5:0] PAR_WR_LEN_HI = 6'h23;
  // Parameter reset values.
  localparam logic [7:0] OP_SEL_RST = 8'h01;
  localparam logic [7:0] DIAG_SUP_RST = 8'h00;
  localparam logic [7:0] RETRY_RST = 8'h02;
  localparam logic [15:0] RD_LEN_RST = 16'h0080;
  localparam logic [15:0] WR_LEN_RST = 16'h0080;
  // Channel operation select codes.
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] MODE_COMPACT = 8'h01;
  localparam logic [7:0] MODE_ADVANCED = 8'h02;
  // Command words.
  localparam logic [15:0] CMD_IDLE = 16'h0000;
  localparam logic [15:0] CMD_SENSE = 16'h0010;
  localparam logic [15:0] CMD_BUF_READ = 16'h0011;
  localparam logic [15:0] CMD_BACKUP = 16'h0100;
  localparam logic [15:0] CMD_RESTORE = 16'h0101;
  localparam logic [15:0] CMD_RESET = 16'h0800;
  // Process data byte layout.
  localparam logic [7:0] PD_CTRL_FIRST = 8'h00;
  localparam logic [7:0] PD_CTRL_LAST = 8'h17;
  localparam logic [7:0] PD_DATA_FIRST = 8'h18;
  localparam logic [7:0] PD_DATA_LAST = 8'h97;
  localparam logic [7:0] PD_DIAG_FIRST = 8'h98;
  localparam logic [7:0] PD_DIAG_LAST = 8'h99;
  localparam logic [7:0] PD_STATUS_FIRST = 8'h9a;
  localparam logic [15:0] DATA_AREA_MAX = 16'(PD_DATA_LAST - PD_DATA_FIRST) + 16'h0001;
  // Response word and diagnostic bits.
  localparam int RESP_BUSY_BIT = 15;
  localparam int RESP_ERR_BIT = 14;
  localparam int DIAG_FAULT_BIT = 0;
  localparam int DIAG_OVFL_BIT = 1;
  // Reader transaction kinds.
  typedef enum logic [1:0] {OP_SENSE = 2'b00, OP_CFG_RD = 2'b01, OP_CFG_WR = 2'b10} rdr_op_t;
  // Controller register word addresses.
  localparam logic [7:0] CREG_CMD = 8'h00;
  localparam logic [7:0] CREG_LEN = 8'h01;
  localparam logic [7:0] CREG_START = 8'h02;
  localparam logic [7:0] CREG_PARW = 8'h03;
  localparam logic [7:0] CREG_PARR = 8'h04;
  localparam logic [7:0] CREG_STATUS = 8'h05;
  localparam logic [7:0] CREG_BYTES = 8'h06;
  localparam logic [7:0] CREG_DIAG = 8'h07;
  localparam logic [7:0] CREG_AREA = 8'h08;
  localparam logic [7:0] CREG_DATA = 8'h80;
endpackage : rfid_chan_pkg

/* rtl/rfid_cmd_link_if.sv */
`timescale 1ns/10ps
interface rfid_cmd_link_if;
  logic cmd_valid;
  logic [15:0] cmd_word;
  logic [15:0] cmd_len;
  logic [7:0] cmd_addr;
  logic par_wr;
  logic par_rd;
  logic [5:0] par_idx;
  logic [7:0] par_wdata;
  logic [7:0] par_rdata;
  logic [15:0] response_word;
  logic [15:0] buffered_byte_count;
  logic [15:0] diag_word;
  logic [15:0] rd_area;
  logic [15:0] wr_area;
  logic rd_valid;
  logic [7:0] rd_data;
  logic [7:0] rd_pd_byte;
  modport dev (input cmd_valid, cmd_word, cmd_len, cmd_addr, par_wr, par_rd, par_idx, par_wdata,
    output par_rdata, response_word, buffered_byte_count, diag_word, rd_area, wr_area, rd_valid, rd_data,
    rd_pd_byte);
  modport ctl (output cmd_valid, cmd_word, cmd_len, cmd_addr, par_wr, par_rd, par_idx, par_wdata,
    input par_rdata, response_word, buffered_byte_count, diag_word, rd_area, wr_area, rd_valid, rd_data,
    rd_pd_byte);
endinterface : rfid_cmd_link_if

/* rtl/rfid_plc_controller.sv */
`timescale 1ns/10ps
module rfid_plc_controller (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Avalon-MM slave.
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Device link.
  rfid_cmd_link_if.ctl lk
);
  import rfid_chan_pkg::*;

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic cmd_valid;
    logic [15:0] cmd_word;
    logic [15:0] len;
    logic [7:0] start;
    logic par_wr;
    logic par_rd;
    logic [5:0] par_idx;
    logic [7:0] par_wdata;
    logic idle_seen;
    logic refused;
    logic [15:0] last_cnt;
    logic [15:0] stable_cnt;
    logic [127:0][7:0] rbuf;
  } state_t;

  state_t r_reg;
  state_t r_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // A request is taken while waitrequest is high and answered one cycle later.
  always_comb begin
    logic stable, busy;
    stable = (r_reg.stable_cnt == 16'(STABLE_CYCLES));
    busy = lk.response_word[RESP_BUSY_BIT];
    r_next = r_reg;
    r_next.cmd_valid = 1'b0;
    r_next.par_wr = 1'b0;
    r_next.par_rd = 1'b0;
    // The count is stable once unchanged for the whole settle time.
    r_next.last_cnt = lk.buffered_byte_count;
    if (lk.buffered_byte_count != r_reg.last_cnt) begin
      r_next.stable_cnt = 16'h0000;
    end else if (!stable) begin
      r_next.stable_cnt = r_reg.stable_cnt + 16'h0001;
    end
    if (lk.rd_valid && lk.rd_pd_byte >= PD_DATA_FIRST && lk.rd_pd_byte <= PD_DATA_LAST) begin
      r_next.rbuf[7'(lk.rd_pd_byte - PD_DATA_FIRST)] = lk.rd_data;
    end
    if (!r_reg.waitreq) begin
      r_next.waitreq = 1'b1;
    end else if (i_avs_write) begin
      r_next.waitreq = 1'b0;
      unique case (i_avs_address)
        CREG_CMD: begin
          // Unsafe orders are refused here instead of reaching the device.
          if (busy ||
              (i_avs_writedata[15:0] == CMD_BUF_READ && !r_reg.idle_seen) ||
              (i_avs_writedata[15:0] == CMD_BUF_READ && r_reg.start[0] && !stable)) begin
            r_next.refused = 1'b1;
          end else begin
            r_next.refused = 1'b0;
            r_next.cmd_valid = 1'b1;
            r_next.cmd_word = i_avs_writedata[15:0];
            r_next.idle_seen = (i_avs_writedata[15:0] == CMD_IDLE) ||
                               (r_reg.idle_seen && i_avs_writedata[15:0] == CMD_BUF_READ);
          end
        end
        CREG_LEN: r_next.len = min_len(i_avs_writedata[15:0], lk.buffered_byte_count);
        CREG_START: r_next.start = i_avs_writedata[7:0];
        CREG_PARW: begin
          r_next.par_wr = 1'b1;
          r_next.par_idx = i_avs_writedata[13:8];
          r_next.par_wdata = i_avs_writedata[7:0];
        end
        CREG_PARR: begin
          r_next.par_rd = 1'b1;
          r_next.par_idx = i_avs_writedata[5:0];
        end
        default: ;
      endcase
    end else if (i_avs_read) begin
      r_next.waitreq = 1'b0;
      if (i_avs_address >= CREG_DATA) begin
        r_next.rdata = {24'h000000, r_reg.rbuf[i_avs_address[6:0]]};
      end else begin
        unique case (i_avs_address)
          CREG_CMD: r_next.rdata = {16'h0000, r_reg.cmd_word};
          CREG_LEN: r_next.rdata = {16'h0000, r_reg.len};
          CREG_START: r_next.rdata = {24'h000000, r_reg.start};
          CREG_PARR: r_next.rdata = {24'h000000, lk.par_rdata};
          CREG_STATUS: r_next.rdata = {13'h0000, stable, r_reg.refused, r_reg.idle_seen, lk.response_word};
          CREG_BYTES: r_next.rdata = {16'h0000, lk.buffered_byte_count};
          CREG_DIAG: r_next.rdata = {16'h0000, lk.diag_word};
          CREG_AREA: r_next.rdata = {lk.wr_area, lk.rd_area};
          default: r_next.rdata = 32'h00000000;
        endcase
      end
    end
  end

  // Requested length is capped at the bytes the device holds when the length is written.
  function automatic logic [15:0] min_len(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction : min_len

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      r_reg <= '0;
      r_reg.waitreq <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs, each straight from the state register.
  assign o_avs_readdata = r_reg.rdata;
  assign o_avs_waitrequest = r_reg.waitreq;
  assign lk.cmd_valid = r_reg.cmd_valid;
  assign lk.cmd_word = r_reg.cmd_word;
  assign lk.cmd_len = r_reg.len;
  assign lk.cmd_addr = r_reg.start;
  assign lk.par_wr = r_reg.par_wr;
  assign lk.par_rd = r_reg.par_rd;
  assign lk.par_idx = r_reg.par_idx;
  assign lk.par_wdata = r_reg.par_wdata;
endmodule : rfid_plc_controller

/* verif/rfid_link_asserts.sv */
`timescale 1ns/10ps
module rfid_link_asserts (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Link signals under watch.
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic [15:0] cmd_len,
  input wire logic par_wr,
  input wire logic [5:0] par_idx,
  input wire logic [7:0] par_wdata,
  input wire logic [15:0] response_word,
  input wire logic [15:0] buffered_byte_count,
  input wire logic [15:0] diag_word,
  input wire logic [15:0] rd_area,
  input wire logic [15:0] wr_area,
  input wire logic rd_valid,
  input wire logic [7:0] rd_pd_byte
);
  import rfid_chan_pkg::*;
  typedef struct packed {logic [7:0] mode; logic sup;} shadow_t;
  shadow_t shadow_reg;
  shadow_t shadow_next;
  // Shadow of mode and suppression.
  always_comb begin
    shadow_next = shadow_reg;
    if (par_wr && par_idx == PAR_OP_SEL) shadow_next.mode = par_wdata;
    if (par_wr && par_idx == PAR_DIAG_SUP) shadow_next.sup = (par_wdata == 8'h01);
    if (!i_nrst) shadow_next = '{mode: 8'h01, sup: 1'b0};
  end
  always_ff @(posedge i_ref_clk) begin
    shadow_reg <= shadow_next;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_cmd_taken;
    cmd_valid && !response_word[RESP_BUSY_BIT];
  endsequence
  sequence s_read_go;
    cmd_valid && !response_word[RESP_BUSY_BIT] && cmd_word == CMD_BUF_READ && shadow_reg.mode == MODE_ADVANCED
      && buffered_byte_count != 16'h0000 && cmd_len != 16'h0000;
  endsequence
  sequence s_two_bytes;
    rd_valid ##1 rd_valid;
  endsequence
  property p_resp_cmd;
    s_cmd_taken |=> response_word[11:0] == $past(cmd_word[11:0]);
  endproperty
  a_resp_cmd: assert property (p_resp_cmd) else $error("command not echoed");
  property p_mode_off;
    s_cmd_taken ##0 (shadow_reg.mode == MODE_OFF && cmd_word != CMD_IDLE && cmd_word != CMD_RESET)
      |=> response_word[RESP_ERR_BIT];
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("disabled channel took command");
  property p_read_start;
    s_read_go |=> response_word[RESP_BUSY_BIT] ##1 rd_valid && rd_pd_byte == PD_DATA_FIRST;
  endproperty
  a_read_start: assert property (p_read_start) else $error("read did not start");
  property p_read_end;
    $fell(response_word[RESP_BUSY_BIT]) && response_word[11:0] == CMD_BUF_READ[11:0] |-> rd_valid;
  endproperty
  a_read_end: assert property (p_read_end) else $error("busy fell off the last byte");
  property p_pd_range;
    rd_valid |-> rd_pd_byte inside {[PD_DATA_FIRST:PD_DATA_LAST]};
  endproperty
  a_pd_range: assert property (p_pd_range) else $error("byte outside data area");
  property p_pd_step;
    s_two_bytes |-> rd_pd_byte == 8'($past(rd_pd_byte) + 8'h01);
  endproperty
  a_pd_step: assert property (p_pd_step) else $error("read bytes not consecutive");
  property p_reset_cmd;
    s_cmd_taken ##0 cmd_word == CMD_RESET && shadow_reg.mode != MODE_OFF
      |=> buffered_byte_count == 16'h0000 && !response_word[RESP_BUSY_BIT];
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset left data");
  property p_rd_area;
    rd_area <= DATA_AREA_MAX;
  endproperty
  a_rd_area: assert property (p_rd_area) else $error("read area too large");
  property p_wr_area;
    wr_area <= DATA_AREA_MAX;
  endproperty
  a_wr_area: assert property (p_wr_area) else $error("write area too large");
  property p_diag_sup;
    shadow_reg.sup && $past(shadow_reg.sup) |-> diag_word == 16'h0000;
  endproperty
  a_diag_sup: assert property (p_diag_sup) else $error("diagnostics shown while suppressed");
endmodule : rfid_link_asserts

/* verif/rfid_channel_cmd_buffer_tb_top.sv */
`timescale 1ns/10ps
module rfid_channel_cmd_buffer_tb_top;
  import rfid_chan_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0, wr = 1'b0, tv = 1'b0, ack = 1'b0, flt = 1'b0, wq, req;
  logic [31:0] wd = 32'h0, epc = 32'h0, rq;
  logic [7:0] adr2_unused;
  logic [1:0] cnt = 2'h0;
  rdr_op_t op;
  logic [3:0] ra;
  logic [7:0] rr = 8'h00, rw;
  logic [7:0] wlog [16];
  int nf = 0, lim = 0, cyc = 0, n_fail = 0, n_tests = 0;
  rfid_cmd_link_if lk ();
  rfid_channel_cmd_buffer u_rfid_channel_cmd_buffer (.i_ref_clk, .i_nrst, .lk,
    .i_tag_valid(tv), .i_tag_epc(epc), .o_rdr_req(req), .o_rdr_op(op), .o_rdr_addr(ra), .o_rdr_wdata(rw),
    .i_rdr_ack(ack), .i_rdr_fault(flt), .i_rdr_rdata(rr));
  rfid_plc_controller u_rfid_plc_controller (.i_ref_clk, .i_nrst, .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rq), .o_avs_waitrequest(wq), .lk);
  rfid_link_asserts u_rfid_link_asserts (.i_ref_clk, .i_nrst, .cmd_valid(lk.cmd_valid),
    .cmd_word(lk.cmd_word), .cmd_len(lk.cmd_len), .par_wr(lk.par_wr), .par_idx(lk.par_idx),
    .par_wdata(lk.par_wdata), .response_word(lk.response_word), .buffered_byte_count(lk.buffered_byte_count),
    .diag_word(lk.diag_word), .rd_area(lk.rd_area), .wr_area(lk.wr_area), .rd_valid(lk.rd_valid),
    .rd_pd_byte(lk.rd_pd_byte));
  //////////////////////////////////////////////////////////////////////////////
  always #5 i_ref_clk = ~i_ref_clk;
  // Reader stand-in with a fault budget.
  always @(posedge i_ref_clk) begin
    cnt <= req ? cnt + 2'h1 : 2'h0;
    ack <= req && cnt == 2'h1;
    flt <= req && cnt == 2'h1 && nf < lim;
    if (req && cnt == 2'h1 && nf < lim) nf <= nf + 1;
    rr <= 8'h5a ^ {4'h0, ra};
    if (ack && !flt && op == OP_CFG_WR) wlog[ra] <= rw;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge i_ref_clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (wq !== 1'b0 && n < 100);
    q = rq;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
  endtask : bus
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wrr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(nm, e, q & m);
  endtask : rdc
  task automatic par(input logic [5:0] i, input logic [7:0] v);
    wrr(CREG_PARW, {18'h0, i, v});
  endtask : par
  task automatic rdpar(input logic [5:0] i, input logic [7:0] e);
    wrr(CREG_PARR, {26'h0, i});
    rdc("parameter", CREG_PARR, 32'hff, {24'h0, e});
  endtask : rdpar
  task automatic cmd(input logic [15:0] c);
    wrr(CREG_CMD, {16'h0, c});
  endtask : cmd
  task automatic byt(input logic [15:0] e);
    rdc("count", CREG_BYTES, 32'hffff, {16'h0, e});
  endtask : byt
  task automatic settle;
    logic [31:0] q;
    int n = 0;
    do begin
      bus(CREG_STATUS, 1'b0, 32'h0, q);
      n++;
    end while (q[RESP_BUSY_BIT] !== 1'b0 && n < 300);
  endtask : settle
  task automatic tag(input logic [31:0] e);
    @(posedge i_ref_clk);
    tv <= 1'b1;
    epc <= e;
    @(posedge i_ref_clk);
    tv <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : tag
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_params;
    rdpar(PAR_OP_SEL, 8'h01);
    rdpar(PAR_DIAG_SUP, 8'h00);
    rdpar(PAR_RETRY, 8'h02);
    rdc("areas", CREG_AREA, 32'hffffffff, 32'h00800080);
    par(PAR_RD_LEN, 8'h10);
    par(PAR_RD_LEN_HI, 8'h00);
    par(PAR_WR_LEN, 8'h00);
    par(PAR_WR_LEN_HI, 8'h02);
    rdc("areas", CREG_AREA, 32'hffffffff, 32'h00800010);
  endtask : t_params
  task automatic t_modes;
    par(PAR_OP_SEL, MODE_OFF);
    cmd(CMD_SENSE);
    rdc("error", CREG_STATUS, 32'h4000, 32'h4000);
    par(PAR_OP_SEL, MODE_COMPACT);
    cmd(CMD_IDLE);
    cmd(CMD_BUF_READ);
    settle();
    rdc("error", CREG_STATUS, 32'h4fff, 32'h4011);
  endtask : t_modes
  task automatic t_sense;
    par(PAR_OP_SEL, MODE_ADVANCED);
    wrr(CREG_START, 32'h1);
    cmd(CMD_SENSE);
    settle();
    tag(32'h11223344);
    tag(32'h55667788);
    tag(32'h11223344);
    byt(16'd10);
    cmd(CMD_IDLE);
    tag(32'h99aabbcc);
    byt(16'd15);
    repeat (120) @(posedge i_ref_clk);
    wrr(CREG_LEN, 32'd10);
    cmd(CMD_BUF_READ);
    settle();
    rdc("epc", 8'h81, 32'hff, 32'h44);
    rdc("epc", 8'h84, 32'hff, 32'h11);
    rdc("header", 8'h85, 32'hff, 32'h01);
    rdc("header", 8'h80, 32'hff, 32'h02);
    byt(16'd5);
    tag(32'h11223344);
    tag(32'h99aabbcc);
    byt(16'd10);
    cmd(CMD_RESET);
    byt(16'd0);
    cmd(CMD_SENSE);
    settle();
    tag(32'h99aabbcc);
    byt(16'd5);
    cmd(CMD_RESET);
  endtask : t_sense
  task automatic t_backup;
    lim = nf + 2;
    cmd(CMD_BACKUP);
    settle();
    rdc("error", CREG_STATUS, 32'h4000, 32'h0);
    cmd(CMD_RESTORE);
    settle();
    for (int i = 0; i < 16; i++) chk("restore", {24'h0, 8'h5a ^ 8'(i)}, {24'h0, wlog[i]});
    lim = nf + 3;
    cmd(CMD_BACKUP);
    settle();
    rdc("error", CREG_STATUS, 32'h4000, 32'h4000);
    rdc("diag", CREG_DIAG, 32'h1, 32'h1);
    par(PAR_DIAG_SUP, 8'h01);
    rdc("diag", CREG_DIAG, 32'hffff, 32'h0);
    cmd(CMD_BUF_READ);
    rdc("refused", CREG_STATUS, 32'h20000, 32'h20000);
  endtask : t_backup
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (8) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    t_params();
    t_modes();
    t_sense();
    t_backup();
    conclude();
  end
endmodule : rfid_channel_cmd_buffer_tb_top
